//--- rtl/eep_dev.sv
`timescale 1ns/1ps
module eep_dev #(
	parameter int PROG_CYCLES = eep_pkg::PROG_CYCLES
) (
	// Clocks and reset
	input wire logic mclk,
	input wire logic link_clk,
	input wire logic rst_b,
	// Strap and protect pins
	input wire logic strap_select_bit0,
	input wire logic strap_select_bit1,
	input wire logic strap_select_bit2,
	input wire logic wp,
	// Status in the mclk domain
	output logic prog_busy,
	// Bus side
	eep_if.dev bus
);
	localparam int CW = $clog2(PROG_CYCLES + 1);
	if (PROG_CYCLES < 1) begin : g_bad_prog
		$error("PROG_CYCLES must be at least one");
	end

	typedef enum logic [1:0] {
		DS_IDLE = 2'b00,
		DS_RX = 2'b01,
		DS_TX = 2'b11
	} eep_dst_t;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers on the link clock
	logic [5:0] sy1;
	logic [5:0] sy2;
	logic scl_d;
	logic sda_d;
	logic bsy1;
	logic bsy2;
	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			sy1 <= eep_pkg::LINK_SYNC_RST;
			sy2 <= eep_pkg::LINK_SYNC_RST;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			bsy1 <= 1'b0;
			bsy2 <= 1'b0;
		end else begin
			sy1 <= {wp, strap_select_bit2, strap_select_bit1, strap_select_bit0, bus.scl, bus.sda_in};
			sy2 <= sy1;
			scl_d <= sy2[1];
			sda_d <= sy2[0];
			bsy1 <= prog_busy;
			bsy2 <= bsy1;
		end
	end

	logic s_scl;
	logic s_sda;
	logic start_ev;
	logic stop_ev;
	logic rise;
	logic fall;
	assign s_scl = sy2[1];
	assign s_sda = sy2[0];
	assign start_ev = s_scl && scl_d && sda_d && !s_sda;
	assign stop_ev = s_scl && scl_d && !sda_d && s_sda;
	assign rise = s_scl && !scl_d;
	assign fall = !s_scl && scl_d;

	////////////////////////////////////////////////////////////////////////
	// Protocol engine
	eep_dst_t st, next_st;
	logic [3:0] cnt, next_cnt;
	logic [1:0] bidx, next_bidx;
	logic rw, next_rw;
	logic [7:0] sh, next_sh;
	logic [12:0] addr, next_addr;
	logic oe, next_oe;
	logic reject, next_reject;
	logic wp_lat, next_wp_lat;
	logic acked, next_acked;
	logic tgl, next_tgl;
	logic pend, next_pend;
	logic wr_pg;
	logic commit;
	logic busy_eff;
	logic [7:0] mem [eep_pkg::MEM_BYTES];
	logic [7:0] pbuf [eep_pkg::PAGE_BYTES];
	logic [eep_pkg::PAGE_BYTES-1:0] pvalid;

	// Pending flag covers the crossing delay before the busy level returns
	assign busy_eff = pend || bsy2;

	// Next-state logic; START and STOP override any byte in progress
	always_comb begin
		next_st = st;
		next_cnt = cnt;
		next_bidx = bidx;
		next_rw = rw;
		next_sh = sh;
		next_addr = addr;
		next_oe = oe;
		next_reject = reject;
		next_wp_lat = wp_lat;
		next_acked = acked;
		next_tgl = tgl;
		next_pend = bsy2 ? 1'b0 : pend;
		wr_pg = 1'b0;
		commit = 1'b0;
		if (start_ev) begin
			next_st = DS_RX;
			next_cnt = 4'h0;
			next_bidx = 2'h0;
			next_oe = 1'b0;
		end else if (stop_ev) begin
			next_st = DS_IDLE;
			next_oe = 1'b0;
			next_reject = 1'b0;
			if (pvalid != '0 && !reject) begin
				commit = 1'b1;
				next_tgl = !tgl;
				next_pend = 1'b1;
			end
		end else begin
			unique case (st)
				DS_IDLE: begin
					next_oe = 1'b0;
				end
				DS_RX: begin
					if (rise && cnt < eep_pkg::BIT_ACK) begin
						next_sh = {sh[6:0], s_sda};
						next_cnt = cnt + 4'h1;
					end
					if (fall && cnt == eep_pkg::BIT_ACK) begin
						next_cnt = eep_pkg::BIT_DONE;
						unique case (bidx)
							2'h0: begin
								next_oe = sh[7:1] == {eep_pkg::DEV_TYPE, sy2[4:2]} && !busy_eff;
								next_rw = sh[0];
							end
							2'h1: begin
								next_addr = {sh[4:0], addr[7:0]};
								next_oe = 1'b1;
							end
							2'h2: begin
								next_addr = {addr[12:8], sh};
								next_oe = 1'b1;
							end
							default: begin
								next_oe = !wp_lat;
								next_reject = wp_lat || reject;
								if (!wp_lat) begin
									wr_pg = 1'b1;
									next_addr = {addr[12:5], addr[4:0] + 5'h01};
								end
							end
						endcase
						if (!next_oe) begin
							next_st = DS_IDLE;
						end
					end
					if (fall && cnt == eep_pkg::BIT_DONE) begin
						next_oe = 1'b0;
						next_cnt = 4'h0;
						if (bidx != 2'h3) begin
							next_bidx = bidx + 2'h1;
						end
						if (bidx == 2'h2) begin
							next_wp_lat = sy2[5];
						end
						if (bidx == 2'h0 && rw) begin
							next_st = DS_TX;
							next_sh = mem[addr];
							next_oe = !mem[addr][7];
							next_addr = addr + 13'h0001;
						end
					end
				end
				DS_TX: begin
					if (rise && cnt == eep_pkg::BIT_ACK) begin
						next_acked = !s_sda;
						next_cnt = eep_pkg::BIT_DONE;
					end else if (rise && cnt < eep_pkg::BIT_ACK) begin
						next_cnt = cnt + 4'h1;
					end
					if (fall) begin
						if (cnt < eep_pkg::BIT_ACK) begin
							next_sh = {sh[6:0], 1'b0};
							next_oe = !sh[6];
						end else if (cnt == eep_pkg::BIT_ACK) begin
							next_oe = 1'b0;
						end else if (acked) begin
							next_sh = mem[addr];
							next_oe = !mem[addr][7];
							next_addr = addr + 13'h0001;
							next_cnt = 4'h0;
						end else begin
							next_st = DS_IDLE;
						end
					end
				end
				default: begin
					next_st = DS_IDLE;
				end
			endcase
		end
	end

	// Control registers of the link domain
	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= DS_IDLE;
			cnt <= 4'h0;
			bidx <= 2'h0;
			rw <= 1'b0;
			sh <= 8'h00;
			addr <= 13'h0000;
			oe <= 1'b0;
			reject <= 1'b0;
			wp_lat <= 1'b0;
			acked <= 1'b0;
			tgl <= 1'b0;
			pend <= 1'b0;
		end else begin
			st <= next_st;
			cnt <= next_cnt;
			bidx <= next_bidx;
			rw <= next_rw;
			sh <= next_sh;
			addr <= next_addr;
			oe <= next_oe;
			reject <= next_reject;
			wp_lat <= next_wp_lat;
			acked <= next_acked;
			tgl <= next_tgl;
			pend <= next_pend;
		end
	end

	// Array is the erased pattern after reset; the page lands in one cycle
	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < eep_pkg::MEM_BYTES; i++) begin
				mem[i] <= eep_pkg::ERASED;
			end
			for (int j = 0; j < eep_pkg::PAGE_BYTES; j++) begin
				pbuf[j] <= eep_pkg::ERASED;
			end
			pvalid <= '0;
		end else begin
			if (commit) begin
				for (int j = 0; j < eep_pkg::PAGE_BYTES; j++) begin
					if (pvalid[j]) begin
						mem[{addr[12:5], 5'(j)}] <= pbuf[j];
					end
				end
			end
			if (stop_ev || start_ev && reject) begin
				pvalid <= '0;
			end else if (wr_pg) begin
				pbuf[addr[4:0]] <= sh;
				pvalid[addr[4:0]] <= 1'b1;
			end
		end
	end

	// Open drain: only ever pulls low, clock line is never touched
	assign bus.dev_sda_out = 1'b0;
	assign bus.dev_sda_oe = oe;

	////////////////////////////////////////////////////////////////////////
	// Programming timer on mclk, started by a toggle from the link side
	logic t1;
	logic t2;
	logic t3;
	logic [CW-1:0] pcnt, next_pcnt;
	logic next_busy;
	always_comb begin
		next_pcnt = pcnt;
		if (t2 != t3) begin
			next_pcnt = CW'(PROG_CYCLES);
		end else if (pcnt != '0) begin
			next_pcnt = pcnt - CW'(1);
		end
		next_busy = next_pcnt != '0;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			t1 <= 1'b0;
			t2 <= 1'b0;
			t3 <= 1'b0;
			pcnt <= '0;
			prog_busy <= 1'b0;
		end else begin
			t1 <= tgl;
			t2 <= t1;
			t3 <= t2;
			pcnt <= next_pcnt;
			prog_busy <= next_busy;
		end
	end
endmodule // eep_dev

//--- rtl/eep_pkg.sv
// Function
// - Device is slave only, never drives clock
// - Master starts only on an idle bus
// - Data stable while clock high, except conditions
// - START is data falling, clock high
// - STOP is data rising, clock high
// - Address byte matches type and strap levels
// - Eighth address bit: one read, zero write
// - Ninth clock: transmitter releases, receiver acknowledges
// - Byte write: address, two bytes, data, STOP
// - STOP after write starts programming, no acknowledges
// - Page buffer holds up to 32 bytes
// - Offset wraps inside page, later bytes overwrite
// - Whole page committed in one programming cycle
// - Master repeats request until address acknowledged
// - Write-protect high blocks all writes
// - Protect sampled before first data; withhold acknowledge
// - Memory starts with every byte all ones
// - Read shifts out byte at current address
// - Selective read: load address, restart, read
// - Acknowledged reads continue, address wraps whole memory
// - Sample on clock rise, change after fall
package eep_pkg;
	localparam logic [3:0] DEV_TYPE = 4'ha;
	localparam int MEM_AW = 13;
	localparam int MEM_BYTES = 8192;
	localparam int PAGE_OW = 5;
	localparam int PAGE_BYTES = 32;
	localparam logic [7:0] ERASED = 8'hff;
	localparam int MCLK_NS = 10;
	localparam int PROG_TIME_MS = 5;
	localparam int PROG_CYCLES = PROG_TIME_MS * 1000000 / MCLK_NS;
	localparam int SCL_TICK_CYCLES = 25;
	localparam logic [5:0] LINK_SYNC_RST = 6'h03;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_DONE = 4'h9;
	typedef enum logic [1:0] {
		EEP_OP_WRITE = 2'h0,
		EEP_OP_SEL_READ = 2'h1,
		EEP_OP_CUR_READ = 2'h3
	} eep_op_t;
endpackage

//--- rtl/eep_if.sv
`timescale 1ns/1ps
// Two-wire bus; the data wire is resolved here from both open-drain enables
interface eep_if;
	logic scl;
	logic mst_sda_out;
	logic mst_sda_oe;
	logic dev_sda_out;
	logic dev_sda_oe;
	logic sda_in;
	assign sda_in = !((mst_sda_oe && !mst_sda_out) || (dev_sda_oe && !dev_sda_out));
	modport mst (output scl, output mst_sda_out, output mst_sda_oe, input sda_in);
	modport dev (input scl, input sda_in, output dev_sda_out, output dev_sda_oe);
endinterface

//--- rtl/eep_mst.sv
`timescale 1ns/1ps
module eep_mst #(
	parameter int TICK_CYCLES = eep_pkg::SCL_TICK_CYCLES
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Command port
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire eep_pkg::eep_op_t cmd_op,
	input wire logic [2:0] cmd_strap,
	input wire logic [15:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	// Response port
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_err,
	// Bus side
	eep_if.mst bus
);
	localparam int TW = $clog2(TICK_CYCLES);
	if (TICK_CYCLES < 8) begin : g_bad_tick
		$error("TICK_CYCLES must be at least eight");
	end

	typedef enum logic [2:0] {
		MS_IDLE = 3'b000,
		MS_START = 3'b001,
		MS_TX = 3'b011,
		MS_RX = 3'b010,
		MS_STOP = 3'b110
	} eep_mst_t;

	// Byte sent at each step of a transfer
	function automatic logic [7:0] byte_for(input logic [2:0] s, input logic [2:0] strap,
		input eep_pkg::eep_op_t op, input logic [15:0] a, input logic [7:0] d);
		unique case (s)
			3'h0: byte_for = {eep_pkg::DEV_TYPE, strap, op == eep_pkg::EEP_OP_CUR_READ};
			3'h1: byte_for = a[15:8];
			3'h2: byte_for = a[7:0];
			3'h3: byte_for = d;
			default: byte_for = {eep_pkg::DEV_TYPE, strap, 1'b1};
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Data line synchroniser; the device answers from another clock
	logic ms1;
	logic ms2;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ms1 <= 1'b1;
			ms2 <= 1'b1;
		end else begin
			ms1 <= bus.sda_in;
			ms2 <= ms1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bit sequencer: four quarter ticks per clock period
	eep_mst_t st, next_st;
	logic [TW-1:0] tick, next_tick;
	logic [1:0] ph, next_ph;
	logic [3:0] bitn, next_bitn;
	logic [2:0] step, next_step;
	logic [7:0] sh, next_sh;
	logic scl, next_scl;
	logic oe, next_oe;
	logic ack_ok, next_ack_ok;
	logic retry, next_retry;
	eep_pkg::eep_op_t op, next_op;
	logic [2:0] strap, next_strap;
	logic [15:0] addr, next_addr;
	logic [7:0] wdata, next_wdata;
	logic next_cmd_ready;
	logic next_rsp_valid;
	logic [7:0] next_rsp_data;
	logic next_rsp_err;
	logic adv;

	assign adv = tick == TW'(TICK_CYCLES - 1);

	always_comb begin
		next_st = st;
		next_tick = (st == MS_IDLE || adv) ? '0 : tick + TW'(1);
		next_ph = adv ? ph + 2'h1 : ph;
		next_bitn = bitn;
		next_step = step;
		next_sh = sh;
		next_scl = scl;
		next_oe = oe;
		next_ack_ok = ack_ok;
		next_retry = retry;
		next_op = op;
		next_strap = strap;
		next_addr = addr;
		next_wdata = wdata;
		next_cmd_ready = cmd_ready;
		next_rsp_valid = 1'b0;
		next_rsp_data = rsp_data;
		next_rsp_err = rsp_err;
		unique case (st)
			MS_IDLE: begin
				next_ph = 2'h0;
				if (cmd_valid && cmd_ready) begin
					next_st = MS_START;
					next_cmd_ready = 1'b0;
					next_op = cmd_op;
					next_strap = cmd_strap;
					next_addr = cmd_addr;
					next_wdata = cmd_wdata;
					next_step = cmd_op == eep_pkg::EEP_OP_CUR_READ ? 3'h0 : 3'h0;
					next_rsp_err = 1'b0;
				end
			end
			MS_START: begin
				if (adv) begin
					unique case (ph)
						2'h0: begin
							next_scl = 1'b0;
							next_oe = 1'b0;
						end
						2'h1: next_scl = 1'b1;
						2'h2: next_oe = 1'b1;
						default: begin
							next_scl = 1'b0;
							next_st = MS_TX;
							next_bitn = 4'h0;
							next_sh = byte_for(step, strap, op, addr, wdata);
						end
					endcase
				end
			end
			MS_TX: begin
				if (adv) begin
					unique case (ph)
						2'h0: next_oe = bitn < eep_pkg::BIT_ACK && !sh[7];
						2'h1: next_scl = 1'b1;
						2'h2: next_ack_ok = !ms2;
						default: begin
							next_scl = 1'b0;
							next_bitn = bitn + 4'h1;
							next_sh = {sh[6:0], 1'b0};
							if (bitn == eep_pkg::BIT_ACK) begin
								next_bitn = 4'h0;
								next_sh = byte_for(step + 3'h1, strap, op, addr, wdata);
								next_step = step + 3'h1;
								if (!ack_ok) begin
									next_st = MS_STOP;
									next_retry = step == 3'h0 || step == 3'h4;
									next_rsp_err = !(step == 3'h0 || step == 3'h4);
								end else if (step == 3'h0 && op == eep_pkg::EEP_OP_CUR_READ
									|| step == 3'h4) begin
									next_st = MS_RX;
								end else if (step == 3'h2 && op == eep_pkg::EEP_OP_SEL_READ) begin
									next_st = MS_START;
									next_step = 3'h4;
								end else if (step == 3'h3) begin
									next_st = MS_STOP;
								end
							end
						end
					endcase
				end
			end
			MS_RX: begin
				if (adv) begin
					unique case (ph)
						2'h0: next_oe = 1'b0;
						2'h1: next_scl = 1'b1;
						2'h2: begin
							if (bitn < eep_pkg::BIT_ACK) begin
								next_sh = {sh[6:0], ms2};
							end
						end
						default: begin
							next_scl = 1'b0;
							next_bitn = bitn + 4'h1;
							if (bitn == eep_pkg::BIT_ACK) begin
								next_rsp_data = sh;
								next_st = MS_STOP;
							end
						end
					endcase
				end
			end
			MS_STOP: begin
				if (adv) begin
					unique case (ph)
						2'h0: next_oe = 1'b1;
						2'h1: next_scl = 1'b1;
						2'h2: next_oe = 1'b0;
						default: begin
							next_step = 3'h0;
							if (retry) begin
								next_retry = 1'b0;
								next_st = MS_START;
							end else begin
								next_st = MS_IDLE;
								next_rsp_valid = 1'b1;
								next_cmd_ready = 1'b1;
							end
						end
					endcase
				end
			end
			default: next_st = MS_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st <= MS_IDLE;
			tick <= '0;
			ph <= 2'h0;
			bitn <= 4'h0;
			step <= 3'h0;
			sh <= 8'h00;
			scl <= 1'b1;
			oe <= 1'b0;
			ack_ok <= 1'b0;
			retry <= 1'b0;
			op <= eep_pkg::EEP_OP_WRITE;
			strap <= 3'h0;
			addr <= 16'h0000;
			wdata <= 8'h00;
			cmd_ready <= 1'b1;
			rsp_valid <= 1'b0;
			rsp_data <= 8'h00;
			rsp_err <= 1'b0;
		end else begin
			st <= next_st;
			tick <= next_tick;
			ph <= next_ph;
			bitn <= next_bitn;
			step <= next_step;
			sh <= next_sh;
			scl <= next_scl;
			oe <= next_oe;
			ack_ok <= next_ack_ok;
			retry <= next_retry;
			op <= next_op;
			strap <= next_strap;
			addr <= next_addr;
			wdata <= next_wdata;
			cmd_ready <= next_cmd_ready;
			rsp_valid <= next_rsp_valid;
			rsp_data <= next_rsp_data;
			rsp_err <= next_rsp_err;
		end
	end

	// Clock is driven push-pull by the master only; data is open drain
	assign bus.scl = scl;
	assign bus.mst_sda_out = 1'b0;
	assign bus.mst_sda_oe = oe;
endmodule // eep_mst

//--- verification/eep_chk.sv
`timescale 1ns/1ps
module eep_chk #(
	parameter logic [2:0] STRAP = 3'h5
) (
	// Link clock and reset
	input wire logic link_clk,
	input wire logic rst_b,
	// Bus wires
	input wire logic scl,
	input wire logic sda_in,
	input wire logic dev_sda_oe
);
	default clocking cb @(posedge link_clk); endclocking
	default disable iff (!rst_b);

	////////////////////////////////////////////////////////////////////////////////
	logic scl_q, sda_q, frame, rw, acked;
	logic next_frame, next_rw, next_acked;
	logic [3:0] bits, next_bits;
	logic [2:0] bytes, next_bytes;
	logic [7:0] sh, next_sh;
	logic start, stop, rise, ack_slot;

	// Raw wires are watched, so conditions are seen before the device's synchronisers do
	assign start = scl && scl_q && sda_q && !sda_in;
	assign stop = scl && scl_q && !sda_q && sda_in;
	assign rise = scl && !scl_q;
	assign ack_slot = frame && rise && (bits == 4'h8);

	// Bit and byte position inside the current frame
	always_comb begin
		next_frame = frame;
		next_bits = bits;
		next_bytes = bytes;
		next_sh = sh;
		next_rw = rw;
		next_acked = acked;
		if (start) begin
			next_frame = 1'b1;
			next_bits = 4'h0;
			next_bytes = 3'h0;
		end else if (stop) begin
			next_frame = 1'b0;
		end else if (rise) begin
			next_bits = (bits == 4'h8) ? 4'h0 : bits + 4'h1;
			if (bits == 4'h8 && bytes != 3'h7) next_bytes = bytes + 3'h1; // Saturates
			if (bits != 4'h8) next_sh = {sh[6:0], sda_in};
			if (ack_slot && bytes == 3'h0) begin
				next_acked = !sda_in;
				next_rw = sh[0];
			end
		end
	end

	// Helper registers
	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			frame <= 1'b0;
			bits <= 4'h0;
			bytes <= 3'h0;
			sh <= 8'h00;
			rw <= 1'b0;
			acked <= 1'b0;
		end else begin
			scl_q <= scl;
			sda_q <= sda_in;
			frame <= next_frame;
			bits <= next_bits;
			bytes <= next_bytes;
			sh <= next_sh;
			rw <= next_rw;
			acked <= next_acked;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	sequence s_drive_begins;
		$rose(dev_sda_oe);
	endsequence
	sequence s_drive_holds;
		dev_sda_oe[*8];
	endsequence

	AST_QUIET_OUTSIDE_FRAME: assert property (!frame |-> !dev_sda_oe)
		else $error("device drives data outside a frame");
	AST_STABLE_SCL_HIGH: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
		else $error("device data changed while clock high");
	AST_CHANGE_AFTER_FALL: assert property ($changed(dev_sda_oe) |-> !$past(scl, 2))
		else $error("device data changed too soon after clock fall");
	AST_DRIVE_HOLDS: assert property (s_drive_begins |-> s_drive_holds)
		else $error("device pull released early");
	AST_ADDR_MATCH: assert property (ack_slot && bytes == 3'h0 && dev_sda_oe |->
		sh[7:1] == {eep_pkg::DEV_TYPE, STRAP})
		else $error("device acknowledged a foreign address");
	AST_ADDR_RECEIVE: assert property (frame && rise && bytes == 3'h0 && bits != 4'h8 |->
		!dev_sda_oe)
		else $error("device drove data during address bits");
	AST_WRITE_ADDR_ACK: assert property (ack_slot && !rw && acked && (bytes == 3'h1 ||
		bytes == 3'h2) |-> dev_sda_oe)
		else $error("memory address byte not acknowledged");
	AST_READ_RELEASE: assert property (ack_slot && rw && acked && bytes != 3'h0 |-> !dev_sda_oe)
		else $error("device held data during master acknowledge slot");
endmodule // eep_chk

//--- verification/i2c_serial_eeprom_slave_test.sv
`timescale 1ns/1ps
module i2c_serial_eeprom_slave_test;
	typedef struct packed {
		eep_pkg::eep_op_t op;
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wp;
		logic [7:0] exp;
		logic err;
	} eep_row_t;

	////////////////////////////////////////////////////////////////////////////////
	logic mclk = 1'b0;
	logic link_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [2:0] strap = 3'h5;
	logic wp = 1'b0;
	logic cmd_valid = 1'b0;
	eep_pkg::eep_op_t cmd_op = eep_pkg::EEP_OP_WRITE;
	logic [2:0] cmd_strap = 3'h5;
	logic [15:0] cmd_addr = 16'h0000;
	logic [7:0] cmd_wdata = 8'h00;
	logic cmd_ready, rsp_valid, rsp_err, prog_busy, saw;
	logic [7:0] rsp_data;
	int fail_count = 0;
	int n_tests = 0;
	// Ordinary cases; writes back to back force address polling while programming
	eep_row_t rows [10] = '{
		'{eep_pkg::EEP_OP_SEL_READ, 16'h0100, 8'h00, 1'b0, 8'hff, 1'b0},
		'{eep_pkg::EEP_OP_WRITE, 16'h0000, 8'ha5, 1'b0, 8'h00, 1'b0},
		'{eep_pkg::EEP_OP_WRITE, 16'h201f, 8'h3c, 1'b0, 8'h00, 1'b0},
		'{eep_pkg::EEP_OP_CUR_READ, 16'h0000, 8'h00, 1'b0, 8'ha5, 1'b0},
		'{eep_pkg::EEP_OP_SEL_READ, 16'h001f, 8'h00, 1'b0, 8'h3c, 1'b0},
		'{eep_pkg::EEP_OP_WRITE, 16'h1fff, 8'h77, 1'b0, 8'h00, 1'b0},
		'{eep_pkg::EEP_OP_SEL_READ, 16'h1fff, 8'h00, 1'b0, 8'h77, 1'b0},
		'{eep_pkg::EEP_OP_CUR_READ, 16'h0000, 8'h00, 1'b0, 8'ha5, 1'b0},
		'{eep_pkg::EEP_OP_WRITE, 16'h0040, 8'h11, 1'b1, 8'h00, 1'b1},
		'{eep_pkg::EEP_OP_SEL_READ, 16'h0040, 8'h00, 1'b1, 8'hff, 1'b0}
	};

	// Clocks of unrelated rates; the link clock runs free as the device expects
	always #5 mclk = ~mclk;
	always #6 link_clk = ~link_clk;

	////////////////////////////////////////////////////////////////////////////////
	eep_if bus_if();

	eep_mst #(.TICK_CYCLES(16)) i_eep_mst (
		.mclk(mclk),
		.rst_b(rst_b),
		.cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready),
		.cmd_op(cmd_op),
		.cmd_strap(cmd_strap),
		.cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata),
		.rsp_valid(rsp_valid),
		.rsp_data(rsp_data),
		.rsp_err(rsp_err),
		.bus(bus_if)
	);

	// Programming time shortened, yet longer than one address byte so polling is seen
	eep_dev #(.PROG_CYCLES(2000)) i_eep_dev (
		.mclk(mclk),
		.link_clk(link_clk),
		.rst_b(rst_b),
		.strap_select_bit0(strap[0]),
		.strap_select_bit1(strap[1]),
		.strap_select_bit2(strap[2]),
		.wp(wp),
		.prog_busy(prog_busy),
		.bus(bus_if)
	);

	eep_chk #(.STRAP(3'h5)) i_eep_chk (
		.link_clk(link_clk),
		.rst_b(rst_b),
		.scl(bus_if.scl),
		.sda_in(bus_if.sda_in),
		.dev_sda_oe(bus_if.dev_sda_oe)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Issue one command, then wait for its response under a bound
	task automatic run_cmd(input eep_row_t r, input logic [2:0] s);
		int n;
		n = 0;
		wp = r.wp;
		cmd_op = r.op;
		cmd_strap = s;
		cmd_addr = r.addr;
		cmd_wdata = r.wdata;
		cmd_valid = 1'b1;
		do @(posedge mclk); while (cmd_ready !== 1'b1);
		#1 cmd_valid = 1'b0;
		do begin
			@(posedge mclk);
			#1 n++;
		end while (rsp_valid !== 1'b1 && n < 20000);
		cmp_bit(rsp_valid, 1'b1);
	endtask

	task automatic results();
		$display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Watchdog sized well above the expected run of about 36k cycles
	initial begin
		#800_000;
		fail_count++;
		results();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge mclk);
		#1 rst_b = 1'b1;
		repeat (4) @(posedge mclk);
		#1;
		for (int i = 0; i < 10; i++) begin
			run_cmd(rows[i], 3'h5);
			if (rows[i].op == eep_pkg::EEP_OP_WRITE) begin
				cmp_bit(rsp_err, rows[i].err);
				repeat (4) @(posedge mclk);
				#1 cmp_bit(prog_busy, !rows[i].err);
			end else begin
				cmp_byte(rsp_data, rows[i].exp);
				cmp_bit(rsp_err, 1'b0);
			end
		end
		// Foreign strap: device must never pull data while the master retries
		wp = 1'b0;
		cmd_strap = 3'h2;
		cmd_op = eep_pkg::EEP_OP_SEL_READ;
		cmd_valid = 1'b1;
		@(posedge mclk);
		#1 cmd_valid = 1'b0;
		saw = 1'b0;
		repeat (3000) begin
			@(posedge mclk);
			if (bus_if.dev_sda_oe !== 1'b0) saw = 1'b1;
		end
		cmp_bit(saw, 1'b0);
		// Reset in mid-retry; memory returns to the erased state
		#1 rst_b = 1'b0;
		repeat (20) @(posedge mclk);
		cmp_bit(cmd_ready, 1'b1);
		cmp_bit(bus_if.scl, 1'b1);
		cmp_bit(bus_if.dev_sda_oe, 1'b0);
		cmp_bit(prog_busy, 1'b0);
		#1 rst_b = 1'b1;
		repeat (4) @(posedge mclk);
		#1 run_cmd(rows[6], 3'h5);
		cmp_byte(rsp_data, 8'hff);
		results();
	end
endmodule // i2c_serial_eeprom_slave_test
